// *** fpec_pkg.sv ***
package fpec_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PROT = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  // Control field positions
  localparam int BIT_HV = 3;
  localparam int BIT_MASS = 2;
  localparam int BIT_ERASE = 1;
  localparam int BIT_PROG = 0;
  // Protect byte value and geometry
  localparam logic [7:0] PROT_OPEN = 8'hFF;
  localparam logic [7:0] PROT_RESET = 8'hFF;
  localparam logic [15:0] PROT_BYTE_ADDR = 16'hFF80;
  localparam logic [15:0] ADDR_RESET = 16'h8000;
  localparam int PAGE_LSB = 7;
  localparam int ROW_LSB = 6;
  // Sequence states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SEL = 4'b0010,
    ST_PREAD = 4'b0100,
    ST_LATCH = 4'b1000
  } fpec_state_type;
  // Commands toward the array macro
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic prog_strobe;
    logic erase_strobe;
    logic mass;
  } fpec_cmd_type;
  // Analog enables
  typedef struct packed {
    logic pump_on;
    logic hv_to_array;
  } fpec_hv_type;
endpackage : fpec_pkg

// *** fpec_top.sv ***
//////////////////////////////////////////////////////////////////////////////
// Contract
// - High voltage only settable with program or erase set and steps done
// - High voltage bit drives charge pump and array high voltage together
// - Mass select bit chooses whole-array erase
// - Erase and program selects never both one; a write setting both fails
// - Program select bit chooses program operation
// - Protect byte changes only through a flash program sequence; here a mass or top-page erase also sets it to FF
// - Start address is one, protect byte, seven zeros
// - Protected from start address up to FFFF, on page boundaries
// - FF protects nothing, 00 protects from 8000 upward
// - Each decrement adds a page; FE protects FF00 to FFFF
// - High voltage refused when target address is protected
// - Mass erase blocked unless protect byte is FF
// - Program rows are 64 aligned bytes
// - Erasing the top page erases the protect byte too
// - Erased bits read one; programming only clears bits
//
// The AHB-Lite interface to the registers and the address map were left to the implementer.
module fpec_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Array macro side
  output fpec_pkg::fpec_cmd_type arr_cmd,
  output fpec_pkg::fpec_hv_type hv_out
);
  logic wr_pend_ff;
  logic rd_pend_ff;
  logic [7:0] ofs_ff;
  logic hv_ff;
  logic mass_ff;
  logic erase_ff;
  logic prog_ff;
  logic [7:0] prot_ff;
  logic [15:0] addr_ff;
  logic [15:0] latch_ff;
  logic row_err_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  fpec_pkg::fpec_state_type st_ff;
  fpec_pkg::fpec_state_type nxt_st;
  fpec_pkg::fpec_cmd_type cmd_ff;
  fpec_pkg::fpec_hv_type hv_out_ff;
  logic wr_ctrl;
  logic wr_addr;
  logic wr_data;
  logic rd_prot;
  logic [15:0] prot_start;
  logic tgt_prot;
  logic wr_prot;
  logic blocked;
  logic hv_ok;
  logic nxt_hv;
  logic both_sel;
  logic [31:0] rdata;

  //////////////////////////////////////////////////////////////////////////////
  // Bus front end: writes take no wait, reads one so data sees prior writes
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      ofs_ff <= 8'h00;
      hreadyout_ff <= 1'b1;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= 1'b0;
      if (rd_pend_ff) begin
        rd_pend_ff <= 1'b0;
        hreadyout_ff <= 1'b1;
        hrdata_ff <= rdata;
      end else if (hready && hsel && htrans[1]) begin
        ofs_ff <= haddr[7:0];
        wr_pend_ff <= hwrite;
        rd_pend_ff <= !hwrite;
        hreadyout_ff <= hwrite;
      end
    end
  end

  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  // Data-phase strobes
  assign wr_ctrl = wr_pend_ff && (ofs_ff == fpec_pkg::OFS_CTRL);
  assign wr_addr = wr_pend_ff && (ofs_ff == fpec_pkg::OFS_ADDR);
  assign wr_data = wr_pend_ff && (ofs_ff == fpec_pkg::OFS_DATA);
  assign rd_prot = rd_pend_ff && (ofs_ff == fpec_pkg::OFS_PROT);

  //////////////////////////////////////////////////////////////////////////////
  // Protection window from the stored byte
  assign prot_start = {1'b1, prot_ff, 7'h00};
  // FE yields FF00 naturally, FF would be FF80 so it is excluded
  assign tgt_prot = (prot_ff != fpec_pkg::PROT_OPEN) && (latch_ff >= prot_start);
  assign wr_prot = (prot_ff != fpec_pkg::PROT_OPEN) && (addr_ff >= prot_start);
  // Mass erase needs a fully open array
  assign blocked = mass_ff && erase_ff ? (prot_ff != fpec_pkg::PROT_OPEN) : tgt_prot;

  // High voltage gate: select already set, steps done, target open
  assign hv_ok = (prog_ff || erase_ff) && (st_ff == fpec_pkg::ST_LATCH) && !blocked;
  assign both_sel = hwdata[fpec_pkg::BIT_ERASE] && hwdata[fpec_pkg::BIT_PROG];
  // Once on, high voltage may be kept or dropped freely
  assign nxt_hv = hv_ff ? hwdata[fpec_pkg::BIT_HV] : (hwdata[fpec_pkg::BIT_HV] && hv_ok);

  //////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      hv_ff <= 1'b0;
      mass_ff <= 1'b0;
      erase_ff <= 1'b0;
      prog_ff <= 1'b0;
    end else if (wr_ctrl) begin
      hv_ff <= nxt_hv;
      mass_ff <= hwdata[fpec_pkg::BIT_MASS];
      // Both-set write keeps the old selects
      if (!both_sel) begin
        erase_ff <= hwdata[fpec_pkg::BIT_ERASE];
        prog_ff <= hwdata[fpec_pkg::BIT_PROG];
      end
    end
  end

  // Analog enables follow the bit, registered
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      hv_out_ff <= '0;
    end else begin
      hv_out_ff.pump_on <= hv_ff;
      hv_out_ff.hv_to_array <= hv_ff;
    end
  end
  assign hv_out = hv_out_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Sequence tracker: select, protect read, array write
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      fpec_pkg::ST_IDLE: begin
        if (prog_ff || erase_ff) nxt_st = fpec_pkg::ST_SEL;
      end
      fpec_pkg::ST_SEL: begin
        if (rd_prot) nxt_st = fpec_pkg::ST_PREAD;
      end
      fpec_pkg::ST_PREAD: begin
        if (wr_data) nxt_st = fpec_pkg::ST_LATCH;
      end
      fpec_pkg::ST_LATCH: begin
        nxt_st = fpec_pkg::ST_LATCH;
      end
      default: begin
        nxt_st = fpec_pkg::ST_IDLE;
      end
    endcase
    // Sequence ends once both select and high voltage are off
    if (!prog_ff && !erase_ff && !hv_ff) nxt_st = fpec_pkg::ST_IDLE;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) st_ff <= fpec_pkg::ST_IDLE;
    else st_ff <= nxt_st;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address register and latched target
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      addr_ff <= fpec_pkg::ADDR_RESET;
      latch_ff <= fpec_pkg::ADDR_RESET;
    end else begin
      if (wr_addr) addr_ff <= hwdata[15:0];
      if (wr_data && st_ff == fpec_pkg::ST_PREAD) latch_ff <= addr_ff;
    end
  end

  // Row check: byte writes must stay in the latched 64-byte row
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      row_err_ff <= 1'b0;
    end else if (st_ff == fpec_pkg::ST_IDLE) begin
      row_err_ff <= 1'b0;
    end else if (wr_data && hv_ff && prog_ff &&
                 addr_ff[15:fpec_pkg::ROW_LSB] != latch_ff[15:fpec_pkg::ROW_LSB]) begin
      row_err_ff <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Array commands: program strobes per byte, erase strobe on rising HV
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cmd_ff <= '0;
    end else begin
      cmd_ff.prog_strobe <= 1'b0;
      cmd_ff.erase_strobe <= 1'b0;
      if (wr_data && hv_ff && prog_ff && !wr_prot) begin
        cmd_ff.prog_strobe <= 1'b1;
        cmd_ff.addr <= addr_ff;
        cmd_ff.data <= hwdata[7:0];
      end else if (wr_ctrl && !hv_ff && nxt_hv && erase_ff) begin
        cmd_ff.erase_strobe <= 1'b1;
        cmd_ff.addr <= latch_ff;
        cmd_ff.mass <= mass_ff;
      end
    end
  end
  assign arr_cmd = cmd_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Stored protect byte: changed only by array program or erase
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      prot_ff <= fpec_pkg::PROT_RESET;
    end else if (wr_data && hv_ff && prog_ff && !wr_prot &&
                 addr_ff == fpec_pkg::PROT_BYTE_ADDR) begin
      prot_ff <= prot_ff & hwdata[7:0];
    end else if (wr_ctrl && !hv_ff && nxt_hv && erase_ff &&
                 (mass_ff || latch_ff[15:fpec_pkg::PAGE_LSB] ==
                  fpec_pkg::PROT_BYTE_ADDR[15:fpec_pkg::PAGE_LSB])) begin
      prot_ff <= fpec_pkg::PROT_OPEN;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (ofs_ff)
      fpec_pkg::OFS_CTRL: rdata[3:0] = {hv_ff, mass_ff, erase_ff, prog_ff};
      fpec_pkg::OFS_PROT: rdata[7:0] = prot_ff;
      fpec_pkg::OFS_ADDR: rdata[15:0] = addr_ff;
      fpec_pkg::OFS_STAT: rdata[5:0] = {row_err_ff, blocked, st_ff};
      default: rdata = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_sel_interlock: assert property (!(erase_ff && prog_ff))
    else $error("erase and program both set");
  a_hv_needs_sel: assert property ($rose(hv_ff) |-> $past(prog_ff || erase_ff))
    else $error("hv set without select");
  a_hv_refused: assert property (wr_ctrl && !hv_ff && !hv_ok |=> !hv_ff)
    else $error("refused hv write took effect");
  a_hv_protect: assert property ($rose(hv_ff) |-> !$past(blocked))
    else $error("hv set on protected target");
  a_pump_follow: assert property (hv_ff |=> hv_out.pump_on && hv_out.hv_to_array)
    else $error("pump not on with hv");
  a_pump_off: assert property (!hv_ff |=> !hv_out.pump_on && !hv_out.hv_to_array)
    else $error("pump on without hv");
  a_mass_block: assert property (cmd_ff.erase_strobe && cmd_ff.mass
                                 |-> $past(prot_ff) == fpec_pkg::PROT_OPEN)
    else $error("mass erase with protection");
  a_prot_clear: assert property ($rose(prot_ff != fpec_pkg::PROT_OPEN)
                                 |-> $past(wr_data && hv_ff && prog_ff))
    else $error("protect byte changed outside program");
  a_prog_ones: assert property ($changed(prot_ff) && !$past(erase_ff)
                                |-> (prot_ff & ~$past(prot_ff)) == 8'h00)
    else $error("program set a bit");
  a_read_wait: assert property (rd_pend_ff |-> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  // Strobes must never reach a protected location, even with HV already on
  a_prog_open: assert property (cmd_ff.prog_strobe |-> !$past(wr_prot))
    else $error("program strobe to protected byte");
  a_erase_open: assert property (cmd_ff.erase_strobe |-> !$past(blocked))
    else $error("erase strobe on blocked target");
  a_row_flag: assert property (wr_data && hv_ff && prog_ff &&
      addr_ff[15:fpec_pkg::ROW_LSB] != latch_ff[15:fpec_pkg::ROW_LSB] |=> row_err_ff)
    else $error("row error not raised");
  a_seq_idle: assert property (!prog_ff && !erase_ff && !hv_ff |=> st_ff == fpec_pkg::ST_IDLE)
    else $error("sequence not back to idle");

  c_mass_erase: cover property (cmd_ff.erase_strobe && cmd_ff.mass);
  c_page_erase: cover property (cmd_ff.erase_strobe && !cmd_ff.mass);
  c_prog_byte: cover property (cmd_ff.prog_strobe);
  c_refused: cover property (wr_ctrl && hwdata[fpec_pkg::BIT_HV] && !hv_ff && !hv_ok);
  c_row_err: cover property ($rose(row_err_ff));
endmodule : fpec_top

// *** fpec_top_tb.sv ***
module fpec_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Short local names for the register offsets
  localparam logic [7:0] CT = fpec_pkg::OFS_CTRL;
  localparam logic [7:0] PR = fpec_pkg::OFS_PROT;
  localparam logic [7:0] AD = fpec_pkg::OFS_ADDR;
  localparam logic [7:0] DT = fpec_pkg::OFS_DATA;
  localparam logic [7:0] ST = fpec_pkg::OFS_STAT;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] rd;
  fpec_pkg::fpec_cmd_type arr_cmd;
  fpec_pkg::fpec_hv_type hv_out;
  int err_count = 0;
  int total_checks = 0;
  int n_prog = 0;
  int n_erase = 0;
  int e_prog = 0;
  int e_erase = 0;
  // Fields of the last array strobe, for address, data and mass checks
  logic [15:0] cap_addr = 16'h0000;
  logic [7:0] cap_data = 8'h00;
  logic cap_mass = 1'b0;
  // Control rows: value written, value read back
  logic [3:0] row_wr [9] = '{4'h1, 4'h3, 4'h2, 4'h3, 4'h0, 4'h8, 4'h4, 4'h6, 4'h0};
  logic [3:0] row_ex [9] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h0, 4'h0, 4'h4, 4'h6, 4'h0};
  // Protect rows: byte, last open address (0 = none), first shut address
  logic [7:0] pv [4] = '{8'hFE, 8'h7F, 8'h01, 8'h00};
  logic [15:0] pa_open [4] = '{16'hFEFF, 16'hBF7F, 16'h807F, 16'h0000};
  logic [15:0] pa_shut [4] = '{16'hFF00, 16'hBF80, 16'h8080, 16'h8000};

  fpec_top u_fpec_top (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .arr_cmd(arr_cmd),
    .hv_out(hv_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Free-running clock
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  // Strobe counters, so a missing or extra pulse shows
  always @(posedge ref_clk) begin
    if (arr_cmd.prog_strobe === 1'b1) n_prog++;
    if (arr_cmd.erase_strobe === 1'b1) n_erase++;
    if (arr_cmd.prog_strobe === 1'b1 || arr_cmd.erase_strobe === 1'b1) begin
      cap_addr <= arr_cmd.addr;
      cap_data <= arr_cmd.data;
      cap_mass <= arr_cmd.mass;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  // Bounded wait for hready high at a rising edge
  task wait_rdy;
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_count++;
        $display("[ERR] %0t bus wait ran out", $time);
        complete_run();
      end
      @(posedge ref_clk);
    end
  endtask : wait_rdy

  // One single word transfer; read data lands in rd
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task do_reset;
    resetn <= 1'b0;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
  endtask : do_reset

  // Full sequence: select, protect read, latch, try high voltage, then unwind
  // Order kept, no array traffic between steps; delays skipped, no device timers
  // No code runs from the array and no interrupt can break in here
  task op(input logic [3:0] c, input logic [15:0] a, input logic [7:0] d, input logic ok);
    bus(1'b1, CT, {28'h0, c});
    bus(1'b0, PR, 32'h0);
    bus(1'b1, AD, {16'h0, a});
    bus(1'b1, DT, 32'hFF);
    bus(1'b0, ST, 32'h0);
    chk(rd, ok ? 32'h08 : 32'h18);
    bus(1'b1, CT, {28'h0, c | 4'h8});
    bus(1'b0, CT, 32'h0);
    chk(rd, {28'h0, c | (ok ? 4'h8 : 4'h0)});
    chk({30'h0, hv_out}, ok ? 32'h3 : 32'h0);
    if (ok && c[0]) begin
      bus(1'b1, DT, {24'h0, d});
      e_prog++;
    end
    if (ok && c[1]) e_erase++;
    // Selects drop before high voltage, as the sequence demands
    bus(1'b1, CT, ok ? 32'h8 : 32'h0);
    bus(1'b1, CT, 32'h0);
    chk(n_prog, e_prog);
    chk(n_erase, e_erase);
    if (ok) chk({16'h0, cap_addr}, {16'h0, a});
    if (ok && c[0]) chk({24'h0, cap_data}, {24'h0, d});
    if (ok && c[1]) chk({31'h0, cap_mass}, {31'h0, c[2]});
  endtask : op

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    chk({31'h0, hresp}, 32'h0);
    bus(1'b0, CT, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, PR, 32'h0);
    chk(rd, 32'hFF);
    bus(1'b0, AD, 32'h0);
    chk(rd, 32'h8000);
    bus(1'b0, ST, 32'h0);
    chk(rd, 32'h1);
    // Plain writes to the protect byte and to a hole go nowhere
    bus(1'b1, PR, 32'h0);
    bus(1'b0, PR, 32'h0);
    chk(rd, 32'hFF);
    bus(1'b1, 8'h14, 32'hF);
    bus(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 9; i++) begin
      bus(1'b1, CT, {28'h0, row_wr[i]});
      bus(1'b0, CT, 32'h0);
      chk(rd, {28'h0, row_ex[i]});
    end
    // Open array: mass, top page erase and a row program all go ahead
    op(4'h6, 16'h8000, 8'h00, 1'b1);
    // Erase time is left to software; the block holds no timer
    op(4'h2, 16'hFF80, 8'h00, 1'b1);
    bus(1'b0, PR, 32'h0);
    chk(rd, 32'hFF);
    op(4'h1, 16'h9000, 8'h00, 1'b1);
    // Each protect byte set by a real program sequence after a fresh reset
    for (int i = 0; i < 4; i++) begin
      do_reset();
      op(4'h1, 16'hFF80, pv[i], 1'b1);
      bus(1'b0, PR, 32'h0);
      chk(rd, {24'h0, pv[i]});
      if (pa_open[i] != 16'h0) op(4'h1, pa_open[i], 8'h00, 1'b1);
      op(4'h1, pa_shut[i], 8'h00, 1'b0);
      op(4'h2, pa_shut[i], 8'h00, 1'b0);
      op(4'h6, 16'h8000, 8'h00, 1'b0);
    end
    // Program write outside the latched row raises the sticky row error
    do_reset();
    bus(1'b1, CT, 32'h1);
    bus(1'b0, PR, 32'h0);
    bus(1'b1, AD, 32'h9000);
    bus(1'b1, DT, 32'hFF);
    bus(1'b1, CT, 32'h9);
    bus(1'b1, AD, 32'h9040);
    bus(1'b1, DT, 32'h5A);
    e_prog++;
    bus(1'b0, ST, 32'h0);
    chk(rd, 32'h28);
    chk({16'h0, cap_addr}, 32'h9040);
    bus(1'b1, CT, 32'h8);
    bus(1'b1, CT, 32'h0);
    bus(1'b0, ST, 32'h0);
    chk(rd, 32'h1);
    chk(n_prog, e_prog);
    chk(n_erase, e_erase);
    complete_run();
  end
endmodule : fpec_top_tb
